// File: pci_defs.svh
/*
 * Offsets, field positions, codes and sizes of the parameter channel
 * interpreter. Assumes inclusion by bare name from the design file.
 */
`ifndef PCI_DEFS_SVH
`define PCI_DEFS_SVH

// ----------------------------------------------------------------
// Register map (byte addresses)
// ----------------------------------------------------------------
`define PCI_OFS_RXBYTE   12'h000
`define PCI_OFS_STATUS   12'h004
`define PCI_OFS_ADDR     12'h008
`define PCI_OFS_TXPOP    12'h00c
`define PCI_PAGE_ATTR    4'h1
`define PCI_PAGE_VAL     4'h2
`define PCI_PAGE_LOG     4'h3
`define PCI_ADDR_RST     7'h01

// ----------------------------------------------------------------
// Attribute word fields
// ----------------------------------------------------------------
`define PCI_A_TYPE_LSB   11
`define PCI_A_WR         15
`define PCI_A_BUS        16
`define PCI_A_ARR        17
`define PCI_A_FLK        18
`define PCI_A_RLK        19
`define PCI_A_SIZE_LSB   20

// ----------------------------------------------------------------
// Commands, replies, errors, data types
// ----------------------------------------------------------------
`define PCI_CMD_NONE     4'h0
`define PCI_CMD_READ     4'h1
`define PCI_CMD_WRW      4'h2
`define PCI_CMD_WRD      4'h3
`define PCI_CMD_NVD      4'hd
`define PCI_CMD_NVW      4'he
`define PCI_CMD_TEXT     4'hf
`define PCI_REP_NONE     4'h0
`define PCI_REP_WORD     4'h1
`define PCI_REP_DWORD    4'h2
`define PCI_REP_ERR      4'h7
`define PCI_REP_TEXT     4'hf
`define PCI_ERR_NOPAR    8'd0
`define PCI_ERR_NOWR     8'd1
`define PCI_ERR_LIMIT    8'd2
`define PCI_ERR_SUBIDX   8'd3
`define PCI_ERR_NOARR    8'd4
`define PCI_ERR_TYPE     8'd5
`define PCI_ERR_MODE     8'd17
`define PCI_ERR_NOBUS    8'd130
`define PCI_ERR_FACT     8'd131
`define PCI_DT_I16       4'd3
`define PCI_DT_I32       4'd4
`define PCI_DT_U8        4'd5
`define PCI_DT_U16       4'd6
`define PCI_DT_U32       4'd7
`define PCI_DT_TEXT      4'd9
`define PCI_IND_TXT_RD   8'h04
`define PCI_IND_TXT_WR   8'h05

// ----------------------------------------------------------------
// Telegram framing
// ----------------------------------------------------------------
`define PCI_STX          8'h02
`define PCI_DATA_BYTES   8'd12
`define PCI_LGE_PARAM    8'd14
`define PCI_TXT_FIXED    8'd10
`define PCI_TXT_N        8'd4
`define PCI_TX_BYTES     5'd16

`endif

// File: pci_pkg.sv
/*
 * Types of the parameter channel interpreter.
 * Assumes nothing of its surroundings.
 */
package pci_pkg;
	typedef enum logic [2:0] {
		RX_IDLE = 3'b001,
		RX_LEN  = 3'b010,
		RX_BODY = 3'b100
	} pci_rx_state_t;
endpackage

// File: pci_param_channel.sv
/*
 * Parameter channel interpreter with AXI4-Lite register access.
 * Software pushes received telegram bytes, pops reply bytes and
 * loads the parameter table. Assumes drive_running, factory_setup_sel,
 * proc_status and proc_freq come from logic on aclk.
 */
// Decided for this implementation: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "pci_defs.svh"

module pci_param_channel
	import pci_pkg::*;
#(
	parameter int PARAM_CNT = 8,
	parameter int LOG_DEPTH = 8
) (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [11:0] awaddr,
	input  wire logic        wvalid,
	output logic             wready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	output logic             bvalid,
	input  wire logic        bready,
	output logic [1:0]       bresp,
	input  wire logic        arvalid,
	output logic             arready,
	input  wire logic [11:0] araddr,
	output logic             rvalid,
	input  wire logic        rready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	input  wire logic        drive_running,
	input  wire logic        factory_setup_sel,
	input  wire logic [15:0] proc_status,
	input  wire logic [15:0] proc_freq,
	output logic             nvm_store,
	output logic [5:0]       nvm_slot
);
	localparam int IW = $clog2(PARAM_CNT);
	localparam int LW = $clog2(LOG_DEPTH);

	initial begin
		if (PARAM_CNT < 2 || PARAM_CNT > 64 || LOG_DEPTH < 2 ||
		    LOG_DEPTH > 64)
			$error("pci_param_channel: table sizes out of range");
	end

	function automatic logic [31:0] merge(input logic [31:0] o,
		input logic [31:0] n, input logic [3:0] s);
		logic [31:0] r;
		r = o;
		for (int b = 0; b < 4; b++)
			if (s[b])
				r[b*8 +: 8] = n[b*8 +: 8];
		return r;
	endfunction

	// --------------------------------------------------------------
	// Storage
	// --------------------------------------------------------------
	logic [31:0]   attr_mem [PARAM_CNT];
	logic [31:0]   val_mem  [PARAM_CNT];
	logic [7:0]    log_mem  [LOG_DEPTH];
	logic [7:0]    rx_buf   [12];
	logic [7:0]    tx_mem   [16];
	logic [7:0]    tx_nxt   [16];
	pci_rx_state_t rx_state_r;
	logic [7:0]    bcc_r, left_r, cnt_r, adr_r;
	logic [6:0]    my_addr_r;
	logic          exec_go_r, bcast_r;
	logic [4:0]    tx_len_r, tx_rd_r;
	logic          awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
	logic [1:0]    bresp_r, rresp_r;
	logic [31:0]   rdata_r;
	logic          nvm_store_r;
	logic [5:0]    nvm_slot_r;

	// --------------------------------------------------------------
	// Bus decode
	// --------------------------------------------------------------
	wire        wr_fire  = awready_r;
	wire        rd_fire  = arready_r;
	wire [6:0]  wtix     = {1'b0, awaddr[7:2]};
	wire [6:0]  rtix     = {1'b0, araddr[7:2]};
	wire        w_rx     = awaddr == `PCI_OFS_RXBYTE;
	wire        w_adr    = awaddr == `PCI_OFS_ADDR;
	wire        w_attr   = awaddr[11:8] == `PCI_PAGE_ATTR &&
	                       wtix < 7'(PARAM_CNT);
	wire        w_val    = awaddr[11:8] == `PCI_PAGE_VAL &&
	                       wtix < 7'(PARAM_CNT);
	wire        w_log    = awaddr[11:8] == `PCI_PAGE_LOG &&
	                       wtix < 7'(LOG_DEPTH);
	wire        w_ok     = w_rx | w_adr | w_attr | w_val | w_log;
	wire        tx_avail = tx_rd_r < tx_len_r;
	wire [7:0]  tx_head  = tx_avail ? tx_mem[tx_rd_r[3:0]] : 8'h0;
	wire        r_pop    = araddr == `PCI_OFS_TXPOP;
	wire        r_attr   = araddr[11:8] == `PCI_PAGE_ATTR &&
	                       rtix < 7'(PARAM_CNT);
	wire        r_val    = araddr[11:8] == `PCI_PAGE_VAL &&
	                       rtix < 7'(PARAM_CNT);
	wire        r_log    = araddr[11:8] == `PCI_PAGE_LOG &&
	                       rtix < 7'(LOG_DEPTH);
	wire        r_sta    = araddr == `PCI_OFS_STATUS;
	wire        r_adr    = araddr == `PCI_OFS_ADDR;
	wire        r_ok     = r_pop | r_attr | r_val | r_log | r_sta |
	                       r_adr | araddr == `PCI_OFS_RXBYTE;
	wire [31:0] rd_mux   =
		r_pop  ? {23'h0, tx_avail, tx_head} :
		r_sta  ? {28'h0, rx_state_r, tx_avail} :
		r_adr  ? {25'h0, my_addr_r} :
		r_attr ? attr_mem[araddr[IW+1:2]] :
		r_val  ? val_mem[araddr[IW+1:2]] :
		r_log  ? {24'h0, log_mem[araddr[LW+1:2]]} : 32'h0;

	// --------------------------------------------------------------
	// AXI4-Lite handshakes
	// --------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_r <= 1'b0;
			wready_r  <= 1'b0;
			bvalid_r  <= 1'b0;
			bresp_r   <= 2'h0;
			arready_r <= 1'b0;
			rvalid_r  <= 1'b0;
			rresp_r   <= 2'h0;
			rdata_r   <= 32'h0;
		end else begin
			awready_r <= awvalid && wvalid && !bvalid_r && !awready_r;
			wready_r  <= awvalid && wvalid && !bvalid_r && !awready_r;
			if (wr_fire) begin
				bvalid_r <= 1'b1;
				bresp_r  <= w_ok ? 2'h0 : 2'h2;
			end else if (bready)
				bvalid_r <= 1'b0;
			arready_r <= arvalid && !rvalid_r && !arready_r;
			if (rd_fire) begin
				rvalid_r <= 1'b1;
				rdata_r  <= rd_mux;
				rresp_r  <= r_ok ? 2'h0 : 2'h2;
			end else if (rready)
				rvalid_r <= 1'b0;
		end
	end

	// --------------------------------------------------------------
	// Telegram receiver
	// --------------------------------------------------------------
	wire       rx_we   = wr_fire && w_rx && wstrb[0];
	wire [7:0] rx_byte = wdata[7:0];
	wire [7:0] bcc_nxt = bcc_r ^ rx_byte;
	wire       bc_addr = adr_r[7] ? adr_r[6:0] == 7'h0 : adr_r[5];
	wire       my_tel  = adr_r[7] ? adr_r[6:0] == my_addr_r :
	                     adr_r[4:0] == my_addr_r[4:0];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rx_state_r <= RX_IDLE;
			bcc_r      <= 8'h0;
			left_r     <= 8'h0;
			cnt_r      <= 8'h0;
			adr_r      <= 8'h0;
			exec_go_r  <= 1'b0;
			bcast_r    <= 1'b0;
		end else begin
			exec_go_r <= 1'b0;
			if (rx_we) begin
				unique case (rx_state_r)
				RX_IDLE: if (rx_byte == `PCI_STX) begin
					bcc_r      <= `PCI_STX;
					rx_state_r <= RX_LEN;
				end
				RX_LEN: begin
					bcc_r      <= bcc_nxt;
					left_r     <= rx_byte;
					cnt_r      <= 8'h0;
					rx_state_r <= rx_byte == 8'h0 ? RX_IDLE : RX_BODY;
				end
				RX_BODY: begin
					bcc_r  <= bcc_nxt;
					cnt_r  <= cnt_r + 8'h1;
					left_r <= left_r - 8'h1;
					if (cnt_r == 8'h0)
						adr_r <= rx_byte;
					else if (cnt_r <= `PCI_DATA_BYTES)
						rx_buf[4'(cnt_r - 8'h1)] <= rx_byte;
					if (left_r == 8'h1) begin
						rx_state_r <= RX_IDLE;
						exec_go_r  <= bcc_nxt == 8'h0 &&
							cnt_r == `PCI_DATA_BYTES + 8'h1 &&
							(my_tel || bc_addr);
						bcast_r    <= bc_addr;
					end
				end
				endcase
			end
		end
	end

	// --------------------------------------------------------------
	// Command decode
	// --------------------------------------------------------------
	wire [15:0] param_identifier_word    = {rx_buf[0], rx_buf[1]};
	wire [7:0]  ind_lo = rx_buf[3];
	wire [7:0]  ind_hi = rx_buf[2];
	wire [31:0] param_value_block    = {rx_buf[4], rx_buf[5], rx_buf[6], rx_buf[7]};
	wire [3:0]  cmd    = param_identifier_word[15:12];
	wire [10:0] param_number_field    = param_identifier_word[10:0];

	logic          hit;
	logic [IW-1:0] hix;
	always_comb begin
		hit = 1'b0;
		hix = '0;
		for (int i = 0; i < PARAM_CNT; i++)
			if (!hit && attr_mem[i][10:0] == param_number_field) begin
				hit = 1'b1;
				hix = IW'(i);
			end
	end

	wire [31:0] at    = attr_mem[hix];
	wire [3:0]  dtype = at[`PCI_A_TYPE_LSB +: 4];
	wire [7:0]  asize = {4'h0, at[`PCI_A_SIZE_LSB +: 4]};
	wire        dw_ty = dtype == `PCI_DT_I32 || dtype == `PCI_DT_U32;
	wire        dw_cm = cmd == `PCI_CMD_WRD || cmd == `PCI_CMD_NVD;
	wire        nv_cm = cmd == `PCI_CMD_NVD || cmd == `PCI_CMD_NVW;
	wire [31:0] newv  = dw_cm ? param_value_block : {16'h0, param_value_block[15:0]};
	wire        known = cmd inside {`PCI_CMD_NONE, `PCI_CMD_READ,
		`PCI_CMD_WRW, `PCI_CMD_WRD, `PCI_CMD_NVD, `PCI_CMD_NVW,
		`PCI_CMD_TEXT};
	wire [LW-1:0] lix = LW'(ind_lo - 8'h1);

	logic        err, do_wr, nv;
	logic [7:0]  en;
	logic [3:0]  code;
	logic [31:0] val;
	always_comb begin
		err   = 1'b0;
		en    = `PCI_ERR_NOPAR;
		code  = `PCI_REP_NONE;
		val   = 32'h0;
		do_wr = 1'b0;
		nv    = 1'b0;
		if (!known)
			err = 1'b1;
		else if (cmd == `PCI_CMD_NONE)
			code = `PCI_REP_NONE;
		else if (!hit)
			err = 1'b1;
		else if (!at[`PCI_A_BUS]) begin
			err = 1'b1;
			en  = `PCI_ERR_NOBUS;
		end else if (cmd == `PCI_CMD_READ) begin
			if (at[`PCI_A_ARR]) begin
				if (ind_lo == 8'h0 || ind_lo > asize ||
				    ind_lo > 8'(LOG_DEPTH)) begin
					err = 1'b1;
					en  = `PCI_ERR_SUBIDX;
				end else begin
					code = `PCI_REP_WORD;
					val  = {24'h0, log_mem[lix]};
				end
			end else if (ind_lo != 8'h0) begin
				err = 1'b1;
				en  = `PCI_ERR_NOARR;
			end else if (dtype == `PCI_DT_TEXT) begin
				err = 1'b1;
				en  = `PCI_ERR_TYPE;
			end else begin
				code = dw_ty ? `PCI_REP_DWORD : `PCI_REP_WORD;
				val  = val_mem[hix];
			end
		end else if (cmd == `PCI_CMD_TEXT) begin
			if (dtype != `PCI_DT_TEXT) begin
				err = 1'b1;
				en  = `PCI_ERR_TYPE;
			end else if (ind_hi == `PCI_IND_TXT_RD) begin
				code = `PCI_REP_TEXT;
				val  = val_mem[hix];
			end else if (ind_hi != `PCI_IND_TXT_WR) begin
				err = 1'b1;
				en  = `PCI_ERR_SUBIDX;
			end else if (!at[`PCI_A_WR]) begin
				err = 1'b1;
				en  = `PCI_ERR_NOWR;
			end else begin
				code  = `PCI_REP_TEXT;
				val   = param_value_block;
				do_wr = 1'b1;
			end
		end else if (!at[`PCI_A_WR]) begin
			err = 1'b1;
			en  = `PCI_ERR_NOWR;
		end else if (factory_setup_sel && at[`PCI_A_FLK]) begin
			err = 1'b1;
			en  = `PCI_ERR_FACT;
		end else if (drive_running && at[`PCI_A_RLK]) begin
			err = 1'b1;
			en  = `PCI_ERR_MODE;
		end else if (dw_cm != dw_ty || dtype == `PCI_DT_TEXT) begin
			err = 1'b1;
			en  = `PCI_ERR_TYPE;
		end else if (dtype == `PCI_DT_U8 && newv[31:8] != 24'h0) begin
			err = 1'b1;
			en  = `PCI_ERR_LIMIT;
		end else begin
			code  = dw_cm ? `PCI_REP_DWORD : `PCI_REP_WORD;
			val   = newv;
			do_wr = 1'b1;
			nv    = nv_cm;
		end
		if (err) begin
			code = `PCI_REP_ERR;
			val  = {24'h0, en};
		end
	end

	// --------------------------------------------------------------
	// Reply assembly
	// --------------------------------------------------------------
	always_comb begin
		tx_nxt[0]  = `PCI_STX;
		tx_nxt[1]  = code == `PCI_REP_TEXT ?
			`PCI_TXT_FIXED + `PCI_TXT_N : `PCI_LGE_PARAM;
		tx_nxt[2]  = adr_r;
		tx_nxt[3]  = {code, param_identifier_word[11:8]};
		tx_nxt[4]  = param_identifier_word[7:0];
		tx_nxt[5]  = rx_buf[2];
		tx_nxt[6]  = rx_buf[3];
		tx_nxt[7]  = val[31:24];
		tx_nxt[8]  = val[23:16];
		tx_nxt[9]  = val[15:8];
		tx_nxt[10] = val[7:0];
		tx_nxt[11] = proc_status[15:8];
		tx_nxt[12] = proc_status[7:0];
		tx_nxt[13] = proc_freq[15:8];
		tx_nxt[14] = proc_freq[7:0];
		tx_nxt[15] = 8'h0;
		for (int i = 0; i < 15; i++)
			tx_nxt[15] = tx_nxt[15] ^ tx_nxt[i];
	end

	// --------------------------------------------------------------
	// Tables, reply buffer and nonvolatile strobe
	// --------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			my_addr_r   <= `PCI_ADDR_RST;
			tx_len_r    <= 5'h0;
			tx_rd_r     <= 5'h0;
			nvm_store_r <= 1'b0;
			nvm_slot_r  <= 6'h0;
			for (int i = 0; i < PARAM_CNT; i++)
				attr_mem[i] <= 32'h0;
		end else begin
			nvm_store_r <= 1'b0;
			if (wr_fire && w_adr && wstrb[0])
				my_addr_r <= wdata[6:0];
			if (wr_fire && w_attr)
				attr_mem[awaddr[IW+1:2]] <=
					merge(attr_mem[awaddr[IW+1:2]], wdata, wstrb);
			if (wr_fire && w_val)
				val_mem[awaddr[IW+1:2]] <=
					merge(val_mem[awaddr[IW+1:2]], wdata, wstrb);
			if (wr_fire && w_log && wstrb[0])
				log_mem[awaddr[LW+1:2]] <= wdata[7:0];
			if (rd_fire && r_pop && tx_avail)
				tx_rd_r <= tx_rd_r + 5'h1;
			if (exec_go_r) begin
				if (do_wr)
					val_mem[hix] <= val;
				nvm_store_r <= do_wr && nv;
				nvm_slot_r  <= 6'(hix);
				if (!bcast_r) begin
					tx_len_r <= `PCI_TX_BYTES;
					tx_rd_r  <= 5'h0;
					for (int i = 0; i < 16; i++)
						tx_mem[i] <= tx_nxt[i];
				end
			end
		end
	end

	assign awready   = awready_r;
	assign wready    = wready_r;
	assign bvalid    = bvalid_r;
	assign bresp     = bresp_r;
	assign arready   = arready_r;
	assign rvalid    = rvalid_r;
	assign rdata     = rdata_r;
	assign rresp     = rresp_r;
	assign nvm_store = nvm_store_r;
	assign nvm_slot  = nvm_slot_r;

	// --------------------------------------------------------------
	// Checks
	// --------------------------------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	AST_REPLY_FIELD: assert property (exec_go_r && !bcast_r
		|=> tx_mem[3][7:4] == $past(code) && tx_len_r == 5'd16)
		else $error("reply code not in identifier top bits");
	AST_ERR_VALUE: assert property (exec_go_r && err && !bcast_r
		|=> tx_mem[3][7:4] == 4'h7 && tx_mem[10] == $past(en))
		else $error("error reply lacks code 7 or number");
	AST_UNKNOWN_CMD: assert property (exec_go_r && !known
		|-> err && code == 4'h7)
		else $error("undefined command not refused");
	AST_NV_STORE: assert property (exec_go_r && !err &&
		(cmd == 4'hd || cmd == 4'he) |=> nvm_store_r ##1 !nvm_store_r)
		else $error("nonvolatile write not strobed once");
	AST_RAM_ONLY: assert property (exec_go_r &&
		(cmd == 4'h2 || cmd == 4'h3) |=> !nvm_store_r)
		else $error("volatile write strobed nonvolatile store");
	AST_TEXT_TYPE: assert property (exec_go_r && cmd == 4'hf &&
		hit && at[`PCI_A_BUS] && dtype != 4'd9 |-> en == 8'd5 && err)
		else $error("text accepted for non-text type");
	AST_TEXT_LEN: assert property (exec_go_r && !bcast_r &&
		code == 4'hf |=> tx_mem[1] == 8'd14)
		else $error("text reply length byte wrong");
	AST_BCAST_QUIET: assert property (exec_go_r && bcast_r
		|=> $stable(tx_len_r) && $stable(tx_rd_r))
		else $error("reply prepared for broadcast");
	AST_NOBUS: assert property (exec_go_r && !bcast_r && known &&
		cmd != 4'h0 && hit && !at[`PCI_A_BUS] |=> tx_mem[10] == 8'd130)
		else $error("no-bus-access error missing");
	AST_BRESP: assert property (awready_r |=> bvalid_r [*1] ##0
		!awready_r)
		else $error("write response not given after accept");

	COV_READ: cover property (exec_go_r && cmd == 4'h1 && !err);
	COV_NVW: cover property (exec_go_r && cmd == 4'he && !err);
	COV_ERR: cover property (exec_go_r && err);
	COV_TEXT: cover property (exec_go_r && code == 4'hf);
endmodule // pci_param_channel

// File: pci_mst.sv
/*
 * Register bus master standing in for the serial bus master: pushes
 * telegram bytes into the receiver and pops reply bytes.
 * Assumes the enclosing testbench provides the task hang().
 */
`timescale 1ns/1ps
module pci_mst (
	input  wire logic        aclk,
	output logic             awvalid,
	input  wire logic        awready,
	output logic [11:0]      awaddr,
	output logic             wvalid,
	input  wire logic        wready,
	output logic [31:0]      wdata,
	output logic [3:0]       wstrb,
	input  wire logic        bvalid,
	output logic             bready,
	input  wire logic [1:0]  bresp,
	output logic             arvalid,
	input  wire logic        arready,
	output logic [11:0]      araddr,
	input  wire logic        rvalid,
	output logic             rready,
	input  wire logic [31:0] rdata,
	input  wire logic [1:0]  rresp
);
	initial begin
		awvalid = 1'b0;
		wvalid = 1'b0;
		bready = 1'b0;
		arvalid = 1'b0;
		rready = 1'b0;
		awaddr = 12'h000;
		araddr = 12'h000;
		wdata = 32'h0;
		wstrb = 4'hf;
	end

	task automatic wr(input logic [11:0] a, input logic [31:0] d,
		output logic [1:0] r);
		int n;
		@(posedge aclk);
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		awaddr <= a;
		wdata <= d;
		bready <= 1'b1;
		n = 0;
		do begin
			@(posedge aclk);
			n++;
			if (awready === 1'b1) awvalid <= 1'b0;
			if (wready === 1'b1) wvalid <= 1'b0;
		end while (bvalid !== 1'b1 && n < 60);
		r = bresp;
		bready <= 1'b0;
		if (n >= 60) testbench.hang();
	endtask

	task automatic rd(input logic [11:0] a, output logic [31:0] d,
		output logic [1:0] r);
		int n;
		@(posedge aclk);
		arvalid <= 1'b1;
		araddr <= a;
		rready <= 1'b1;
		n = 0;
		do begin
			@(posedge aclk);
			n++;
			if (arready === 1'b1) arvalid <= 1'b0;
		end while (rvalid !== 1'b1 && n < 60);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
		if (n >= 60) testbench.hang();
	endtask

	// Frame of start, length 14, address, twelve data bytes, check byte
	task automatic tel(input logic [15:0] param_identifier_word, input logic [15:0] param_index_word,
		input logic [31:0] v, input logic bad,
		input logic [7:0] adr = 8'h01);
		logic [7:0] b [16];
		logic [1:0] r;
		int         i;
		b = '{8'h02, 8'h0e, adr, param_identifier_word[15:8], param_identifier_word[7:0], param_index_word[15:8], param_index_word[7:0],
			v[31:24], v[23:16], v[15:8], v[7:0], 8'h00, 8'h00, 8'h00,
			8'h00, 8'h00};
		for (i = 0; i < 15; i++) b[15] ^= b[i];
		b[15] ^= {7'h00, bad};
		for (i = 0; i < 16; i++) wr(12'h000, {24'h0, b[i]}, r);
	endtask
endmodule // pci_mst

// File: testbench.sv
/*
 * Self-checking bench of the parameter channel interpreter.
 * Assumes pci_mst as register bus master and the design's defaults.
 */
`timescale 1ns/1ps
module testbench;
	logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid;
	logic        bready, arvalid, arready, rvalid, rready, nvm_store;
	logic        drive_running, factory_setup_sel;
	logic [11:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp;
	logic [15:0] proc_status, proc_freq;
	logic [5:0]  nvm_slot;
	int          errors, tests_run;
	int          nv_cnt = 0;
	logic [5:0]  nv_slot;
	logic [8:0]  fl [6] = '{9'h01b, 9'h003, 9'h002, 9'h003, 9'h000, 9'h066};
	logic [3:0]  ty [6] = '{4'd6, 4'd5, 4'd9, 4'd7, 4'd6, 4'd5};
	logic [7:0]  lg [3];

	pci_param_channel u_dut (.aclk(aclk), .aresetn(aresetn),
		.awvalid(awvalid), .awready(awready), .awaddr(awaddr),
		.wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
		.bvalid(bvalid), .bready(bready), .bresp(bresp),
		.arvalid(arvalid), .arready(arready), .araddr(araddr),
		.rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
		.drive_running(drive_running), .factory_setup_sel(factory_setup_sel),
		.proc_status(proc_status), .proc_freq(proc_freq),
		.nvm_store(nvm_store), .nvm_slot(nvm_slot));

	pci_mst u_mst (.aclk(aclk), .awvalid(awvalid), .awready(awready),
		.awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata),
		.wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
		.arvalid(arvalid), .arready(arready), .araddr(araddr),
		.rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp));

	// Counts nonvolatile store strobes and keeps the last slot
	always @(posedge aclk) begin
		if (nvm_store === 1'b1) begin
			nv_cnt  <= nv_cnt + 1;
			nv_slot <= nvm_slot;
		end
	end

	task automatic wrap_up();
		if (errors == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic hang();
		$display("wrong value at %0t: no answer", $time);
		errors++;
		wrap_up();
	endtask

	task automatic cmp(input logic [31:0] g, input logic [31:0] e,
		input string m);
		tests_run++;
		if (g !== e) begin
			errors++;
			$display("wrong value at %0t: %s", $time, m);
		end
	endtask

	// Send one request, pop the whole reply and judge it
	task automatic chk(input logic [3:0] c, input logic [10:0] p,
		input logic [15:0] param_index_word, input logic [31:0] v,
		input logic [3:0] code, input logic [31:0] ev);
		logic [7:0]  q [16];
		logic [31:0] d;
		logic [1:0]  r;
		logic [7:0]  x;
		int          i;
		u_mst.tel({c, 1'b0, p}, param_index_word, v, 1'b0);
		i = 0;
		do begin
			u_mst.rd(12'h004, d, r);
			i++;
		end while (d[0] !== 1'b1 && i < 20);
		if (i >= 20) hang();
		x = 8'h00;
		for (i = 0; i < 16; i++) begin
			u_mst.rd(12'h00c, d, r);
			q[i] = d[7:0];
			x ^= d[7:0];
		end
		cmp({q[0], q[1]}, 32'h020e, "reply frame head");
		cmp({28'h0, q[3][7:4]}, {28'h0, code}, "reply code");
		cmp({21'h0, q[3][2:0], q[4]}, {21'h0, p}, "number");
		cmp({q[7], q[8], q[9], q[10]}, ev, "reply value");
		cmp({24'h0, x}, 32'h0, "check byte");
		cmp({q[2], q[5], q[6]}, {8'h01, param_index_word}, "echo");
		cmp({q[11], q[12], q[13], q[14]}, {proc_status, proc_freq},
			"process words");
	endtask

	initial begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end

	initial begin
		logic [31:0] d, rv, tv;
		logic [1:0]  r;
		int          i;
		aresetn = 1'b0;
		drive_running = 1'b0;
		factory_setup_sel = 1'b0;
		proc_status = 16'h0000;
		proc_freq = 16'h0000;
		errors = 0;
		tests_run = 0;
		void'($urandom(31));
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		proc_status <= 16'($urandom);
		proc_freq <= 16'($urandom);
		u_mst.rd(12'h008, d, r);
		cmp(d, 32'h1, "address after reset");
		u_mst.rd(12'h400, d, r);
		cmp({30'h0, r}, 32'h2, "unmapped read");
		u_mst.wr(12'h400, 32'h0, r);
		cmp({30'h0, r}, 32'h2, "unmapped write");
		for (i = 0; i < 6; i++)
			u_mst.wr(12'h100 + 12'(4 * i), {8'h00, fl[i], ty[i], 11'(10 + i)}, r);
		for (i = 0; i < 3; i++) begin
			lg[i] = 8'(1 + $urandom % 99);
			u_mst.wr(12'h300 + 12'(4 * i), {24'h0, lg[i]}, r);
		end
		tv = $urandom;
		u_mst.wr(12'h208, tv, r);
		rv = $urandom % 65536;
		chk(4'h2, 11'd10, 16'h0, rv, 4'h1, rv);
		u_mst.rd(12'h200, d, r);
		cmp(d, rv, "stored value");
		chk(4'h1, 11'd10, 16'h0100, 32'h0, 4'h1, rv);
		rv = $urandom % 65536;
		chk(4'he, 11'd10, 16'h0, rv, 4'h1, rv);
		rv = $urandom;
		chk(4'hd, 11'd13, 16'h0, rv, 4'h2, rv);
		rv = $urandom;
		chk(4'h3, 11'd13, 16'h0, rv, 4'h2, rv);
		cmp(32'(nv_cnt), 32'd2, "nonvolatile strobes");
		cmp({26'h0, nv_slot}, 32'd3, "nonvolatile slot");
		factory_setup_sel <= 1'b1;
		chk(4'h2, 11'd10, 16'h0, 32'h5, 4'h7, 32'd131);
		factory_setup_sel <= 1'b0;
		drive_running <= 1'b1;
		chk(4'h2, 11'd10, 16'h0, 32'h5, 4'h7, 32'd17);
		drive_running <= 1'b0;
		chk(4'h2, 11'd11, 16'h0, 32'd256, 4'h7, 32'd2);
		chk(4'h2, 11'd11, 16'h0, 32'd200, 4'h1, 32'd200);
		chk(4'h2, 11'd12, 16'h0, 32'h1, 4'h7, 32'd1);
		chk(4'h1, 11'd12, 16'h0, 32'h0, 4'h7, 32'd5);
		chk(4'h2, 11'd14, 16'h0, 32'h1, 4'h7, 32'd130);
		chk(4'h1, 11'd99, 16'h0, 32'h0, 4'h7, 32'd0);
		chk(4'h1, 11'd10, 16'h0001, 32'h0, 4'h7, 32'd4);
		chk(4'h1, 11'd15, 16'h0001, 32'h0, 4'h1, {24'h0, lg[0]});
		chk(4'h1, 11'd15, 16'h0003, 32'h0, 4'h1, {24'h0, lg[2]});
		chk(4'h1, 11'd15, 16'h0004, 32'h0, 4'h7, 32'd3);
		chk(4'hf, 11'd12, 16'h0400, 32'h0, 4'hf, tv);
		chk(4'hf, 11'd12, 16'h0500, 32'h0, 4'h7, 32'd1);
		chk(4'hf, 11'd12, 16'h0600, 32'h0, 4'h7, 32'd3);
		chk(4'hf, 11'd10, 16'h0400, 32'h0, 4'h7, 32'd5);
		chk(4'h0, 11'd10, 16'h0, 32'h0, 4'h0, 32'h0);
		for (i = 4; i < 13; i++)
			chk(4'(i), 11'd10, 16'h0, 32'h0, 4'h7, 32'h0);
		u_mst.tel({4'h1, 1'b0, 11'd10}, 16'h0, 32'h0, 1'b1);
		u_mst.rd(12'h004, d, r);
		cmp({31'h0, d[0]}, 32'h0, "reply to bad frame");
		u_mst.tel({4'h2, 1'b0, 11'd11}, 16'h0, 32'd77, 1'b0, 8'h20);
		u_mst.rd(12'h004, d, r);
		cmp({31'h0, d[0]}, 32'h0, "reply to broadcast");
		u_mst.rd(12'h204, d, r);
		cmp(d, 32'd77, "broadcast write");
		u_mst.tel({4'h2, 1'b0, 11'd11}, 16'h0, 32'd9, 1'b0, 8'h05);
		u_mst.rd(12'h004, d, r);
		cmp({31'h0, d[0]}, 32'h0, "reply to other slave");
		u_mst.rd(12'h204, d, r);
		cmp(d, 32'd77, "write for other slave");
		wrap_up();
	end
endmodule // testbench
